// [addon_pci_window_bases_and_intr.sv]
`timescale 1ns/100ps
module addon_pci_window_bases_and_intr (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Local mode and window masks
  input wire logic i_addon_mode,
  input wire logic i_config_done,
  input wire logic [addon_pkg::NUM_WIN-1:0][addon_pkg::MASK_W-1:0] i_win_mask,
  input wire logic [15:0] i_event_set,
  // CPU register port
  input wire logic i_cpu_wr,
  input wire logic i_cpu_rd,
  input wire logic [8:0] i_cpu_addr,
  input wire logic [31:0] i_cpu_wdata,
  input wire logic [3:0] i_cpu_be,
  output logic [31:0] o_cpu_rdata,
  output logic o_cpu_rvalid,
  // PCI side, sampled from the PCI clock domain
  input wire logic i_pci_clk,
  input wire logic i_pci_cfg_wr,
  input wire logic i_pci_cfg_rd,
  input wire logic i_pci_io_wr,
  input wire logic i_pci_io_rd,
  input wire logic i_pci_mem_wr,
  input wire logic i_pci_mem_rd,
  input wire logic [31:0] i_pci_addr,
  input wire logic [31:0] i_pci_data,
  input wire logic [3:0] i_pci_be,
  output logic [31:0] o_pci_rdata,
  output logic o_pci_rvalid,
  output logic [addon_pkg::NUM_WIN-1:0] o_win_hit,
  // Open-drain interrupt pin
  output logic o_inta_n_o,
  output logic o_inta_n_oe
);
  import addon_pkg::*;

  typedef struct packed {
    pci_in_t s1;
    pci_in_t s2;
    logic clk_s1;
    logic clk_s2;
    logic clk_prev;
    logic [15:0] pci_control_word;
    logic [15:0] pci_event_flags;
    logic [7:0] master_latency_count;
    logic [NUM_WIN-1:0][BASE_W-1:0] win_base;
    logic [29:0] io_locator_field;
    logic [27:0] memory_locator_field;
    logic [31:0] pci_rdata;
    logic pci_rvalid;
    logic [31:0] cpu_rdata;
    logic cpu_rvalid;
    logic [NUM_WIN-1:0] hit;
    logic inta_o;
    logic inta_oe;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  pci_in_t p;
  logic pci_edge;
  logic io_hit;
  logic mem_hit;
  logic set_c;
  logic clr_c;
  logic [15:0] flag_clr;
  logic [31:0] w;
  logic [31:0] wc;

  blk_link_if lnk();

  window_match u_win (
    .lnk(lnk.win_side)
  );

  intr_flag u_int (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .lnk(lnk.int_side)
  );

  // ==========================================================
  // Configuration read mux
  function automatic logic [31:0] cfg_read(input state_t s, input logic [8:0] a,
                                           input logic cpu);
    logic [31:0] r;
    r = '0;
    if (a[8:2] == OFF_PCI_CONTROL_WORD[8:2]) begin
      r = {s.pci_event_flags | EVENT_FLAGS_FIXED, s.pci_control_word};
    end else if (a[8:2] == OFF_CACHE_LINE[8:2]) begin
      r[LATENCY_POS +: 8] = s.master_latency_count;
      if (!cpu) begin
        r[7:0] = CACHE_LINE_WORDS;
      end
    end else if (!cpu && a[8:2] == OFF_INTERRUPT_IO_LOCATOR[8:2]) begin
      r = {s.io_locator_field, IO_SPACE};
    end else if (!cpu && a[8:2] == OFF_INTERRUPT_MEMORY_LOCATOR[8:2]) begin
      r = {s.memory_locator_field, MEM_SPACE};
    end
    for (int i = 0; i < NUM_WIN; i++) begin
      if (!cpu && a[8:2] == OFF_WIN[i][8:2]) begin
        r = {s.win_base[i], WIN_LOW_CONST};
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Sampling and decode of the PCI side
  assign p = st_r.s2;
  assign pci_edge = st_r.clk_s2 & ~st_r.clk_prev;
  assign io_hit = (p.addr[31:IO_POS] == st_r.io_locator_field);
  assign mem_hit = (p.addr[31:MEM_POS] == st_r.memory_locator_field);

  assign lnk.win_base = st_r.win_base;
  assign lnk.win_mask = i_win_mask;
  assign lnk.addr_hi = p.addr[31:BASE_POS];
  assign lnk.match_en = i_addon_mode & i_config_done;
  assign lnk.int_set = set_c;
  assign lnk.int_clr = clr_c;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    set_c = 1'b0;
    clr_c = 1'b0;
    flag_clr = '0;
    w = '0;
    wc = '0;
    // The PCI clock and every PCI input go through two stages together,
    // so the request seen at the detected edge is aligned with it.
    st_nxt.clk_s1 = i_pci_clk;
    st_nxt.clk_s2 = st_r.clk_s1;
    st_nxt.clk_prev = st_r.clk_s2;
    st_nxt.s1 = {i_pci_cfg_wr, i_pci_cfg_rd, i_pci_io_wr, i_pci_io_rd,
                 i_pci_mem_wr, i_pci_mem_rd, i_pci_addr, i_pci_data, i_pci_be};
    st_nxt.s2 = st_r.s1;
    st_nxt.pci_rvalid = 1'b0;
    st_nxt.cpu_rvalid = 1'b0;

    if (pci_edge && p.cfg_wr) begin
      wc = merge_be('0, p.data, p.be);
      if (p.addr[8:2] == OFF_PCI_CONTROL_WORD[8:2]) begin
        if (!i_addon_mode) begin
          w = merge_be({16'h0000, st_r.pci_control_word}, p.data, p.be);
          st_nxt.pci_control_word = w[15:0];
        end
        flag_clr = flag_clr | wc[EVENT_FLAGS_POS +: 16];
      end else if (p.addr[8:2] == OFF_MASTER_LATENCY_COUNT[8:2]) begin
        if (!i_addon_mode) begin
          st_nxt.master_latency_count = p.be[1] ? p.data[LATENCY_POS +: 8] :
                                        st_r.master_latency_count;
        end
      end else if (p.addr[8:2] == OFF_INTERRUPT_IO_LOCATOR[8:2]) begin
        w = merge_be({st_r.io_locator_field, IO_SPACE}, p.data, p.be);
        st_nxt.io_locator_field = w[31:IO_POS];
      end else if (p.addr[8:2] == OFF_INTERRUPT_MEMORY_LOCATOR[8:2]) begin
        w = merge_be({st_r.memory_locator_field, MEM_SPACE}, p.data, p.be);
        st_nxt.memory_locator_field = w[31:MEM_POS];
      end
      for (int i = 0; i < NUM_WIN; i++) begin
        if (p.addr[8:2] == OFF_WIN[i][8:2]) begin
          w = merge_be({st_r.win_base[i], WIN_LOW_CONST}, p.data, p.be);
          st_nxt.win_base[i] = w[31:BASE_POS];
        end
      end
    end
    if (pci_edge && p.cfg_rd) begin
      st_nxt.pci_rdata = cfg_read(st_r, p.addr[8:0], 1'b0);
      st_nxt.pci_rvalid = 1'b1;
    end

    if (pci_edge && ((p.io_wr && io_hit) || (p.mem_wr && mem_hit)) && p.be[0]) begin
      clr_c = 1'b1;
    end
    if (pci_edge && ((p.io_rd && io_hit) || (p.mem_rd && mem_hit))) begin
      st_nxt.pci_rdata = {31'h0000_0000, lnk.int_pend};
      st_nxt.pci_rvalid = 1'b1;
    end

    if (i_cpu_wr) begin
      wc = merge_be('0, i_cpu_wdata, i_cpu_be);
      if (i_cpu_addr[8:2] == OFF_PCI_CONTROL_WORD[8:2]) begin
        if (i_addon_mode) begin
          w = merge_be({16'h0000, st_r.pci_control_word}, i_cpu_wdata, i_cpu_be);
          st_nxt.pci_control_word = w[15:0];
        end
        flag_clr = flag_clr | wc[EVENT_FLAGS_POS +: 16];
      end else if (i_cpu_addr[8:2] == OFF_MASTER_LATENCY_COUNT[8:2]) begin
        if (i_addon_mode && i_cpu_be[1]) begin
          st_nxt.master_latency_count = i_cpu_wdata[LATENCY_POS +: 8];
        end
      end else if (i_cpu_addr[8:2] == OFF_PCI_ENABLE[8:2]) begin
        set_c = wc[ENA_SET_INT_BIT];
      end
    end
    if (i_cpu_rd) begin
      if (i_cpu_addr[8:2] == OFF_PCI_ENABLE[8:2]) begin
        st_nxt.cpu_rdata = '0;
        st_nxt.cpu_rdata[ENA_SET_INT_BIT] = lnk.int_pend;
      end else begin
        st_nxt.cpu_rdata = cfg_read(st_r, i_cpu_addr, 1'b1);
      end
      st_nxt.cpu_rvalid = 1'b1;
    end

    st_nxt.pci_event_flags = (st_r.pci_event_flags & ~flag_clr) | i_event_set;
    // Hits are levels that follow the sampled memory cycle.
    st_nxt.hit = (p.mem_rd || p.mem_wr) ? lnk.win_hit : '0;
    st_nxt.inta_oe = lnk.int_pend;
    st_nxt.inta_o = 1'b0;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.pci_control_word <= CONTROL_RST;
      st_r.pci_event_flags <= EVENT_FLAGS_RST;
      st_r.master_latency_count <= LATENCY_RST;
      st_r.win_base <= {NUM_WIN{WIN_BASE_RST}};
      st_r.io_locator_field <= IO_LOCATOR_RST;
      st_r.memory_locator_field <= MEM_LOCATOR_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_cpu_rdata = st_r.cpu_rdata;
  assign o_cpu_rvalid = st_r.cpu_rvalid;
  assign o_pci_rdata = st_r.pci_rdata;
  assign o_pci_rvalid = st_r.pci_rvalid;
  assign o_win_hit = st_r.hit;
  assign o_inta_n_o = st_r.inta_o;
  assign o_inta_n_oe = st_r.inta_oe;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence cfg_rd_at(logic [8:0] off);
    pci_edge && p.cfg_rd && (p.addr[8:2] == off[8:2]);
  endsequence

  sequence cfg_wr_at(logic [8:0] off);
    pci_edge && p.cfg_wr && (p.addr[8:2] == off[8:2]);
  endsequence

  sequence ireg_rd;
    pci_edge && ((p.io_rd && io_hit) || (p.mem_rd && mem_hit));
  endsequence

  AST_PCI_CTRL_LOCK:
  assert property (cfg_wr_at(OFF_PCI_CONTROL_WORD) ##0 (i_addon_mode && !i_cpu_wr)
                   |=> $stable(st_r.pci_control_word))
    else $error("host wrote control in add-on mode");
  AST_CPU_CTRL_LOCK:
  assert property (i_cpu_wr && !i_addon_mode && !(pci_edge && p.cfg_wr)
                   |=> $stable(st_r.pci_control_word))
    else $error("CPU wrote control outside add-on mode");
  AST_EVENT_SET:
  assert property ((|i_event_set)
                   |=> ((st_r.pci_event_flags & $past(i_event_set)) == $past(i_event_set)))
    else $error("event flag not set");
  AST_EVENT_ONLY_HW:
  assert property ((st_r.pci_event_flags & ~$past(st_r.pci_event_flags)
                    & ~$past(i_event_set)) == '0)
    else $error("event flag set without event");
  AST_WIN_LOW_CONST:
  assert property (cfg_rd_at(OFF_TARGET_WINDOW_BASE_FIRST)
                   |=> (o_pci_rvalid && o_pci_rdata[BASE_POS-1:0] == WIN_LOW_CONST))
    else $error("window low bits wrong");
  AST_IO_SPACE:
  assert property (cfg_rd_at(OFF_INTERRUPT_IO_LOCATOR)
                   |=> (o_pci_rvalid && o_pci_rdata[IO_POS-1:0] == IO_SPACE))
    else $error("I/O space marker wrong");
  AST_MEM_SPACE:
  assert property (cfg_rd_at(OFF_INTERRUPT_MEMORY_LOCATOR)
                   |=> (o_pci_rvalid && o_pci_rdata[MEM_POS-1:0] == MEM_SPACE))
    else $error("memory space marker wrong");
  AST_IREG_READ:
  assert property (ireg_rd |=> (o_pci_rvalid && o_pci_rdata == {31'h0000_0000,
                                                                $past(lnk.int_pend)}))
    else $error("interrupt register read wrong");
  AST_CPU_PEND_BIT:
  assert property (i_cpu_rd && i_cpu_addr[8:2] == OFF_PCI_ENABLE[8:2]
                   |=> (o_cpu_rvalid && o_cpu_rdata[ENA_SET_INT_BIT] == $past(lnk.int_pend)))
    else $error("CPU pending bit wrong");
  AST_INTA_DRIVE:
  assert property (##1 (o_inta_n_oe == $past(lnk.int_pend)) && !o_inta_n_o)
    else $error("INTA drive does not follow pending");

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_chk
      AST_HIT_NEEDS_BASE:
      assert property (o_win_hit[g] |-> ($past(lnk.match_en) &&
                                         $past(lnk.win_base[g]) != WIN_BASE_RST))
        else $error("hit on disabled window");
    end
  endgenerate
endmodule

// [addon_pkg.sv]
// What this block does
// - Control and latency fields take CPU writes in add-on mode, else host writes.
// - Event flags are set only by hardware; writing one clears, zero keeps.
// - In add-on mode after configuration done, window bases steer target decode.
// - Both window base registers reset to zero.
// - Window base low 21 bits read 0x8 and never take part in compare.
// - Base bits 31:21 match address top bits, bits 27:21 masked by window mask.
// - Mask sets window size from 2 MB up to 256 MB.
// - A window base with all-zero address field never matches.
// - I/O locator reads 01 in bits 1:0; bits 31:2 decode interrupt register.
// - Memory locator reads zero in bits 3:0; bits 31:4 decode interrupt register.
// - Interrupt register bit 0 shows pending state; bits 31:1 read zero.
// - CPU read of enable register bit 3 returns the pending bit.
// - A PCI write to interrupt register bit 0 clears pending and releases INTA#, unless a CPU set arrives in the same cycle.
package addon_pkg;
  // ==========================================================
  // Sizes
  localparam int NUM_WIN = 2;
  localparam int MASK_W = 7;
  localparam int BASE_W = 11;
  // ==========================================================
  // Offsets from the register base
  localparam logic [8:0] OFF_PCI_CONTROL_WORD = 9'h104;
  localparam logic [8:0] OFF_PCI_EVENT_FLAGS = 9'h106;
  localparam logic [8:0] OFF_CACHE_LINE = 9'h10C;
  localparam logic [8:0] OFF_MASTER_LATENCY_COUNT = 9'h10D;
  localparam logic [8:0] OFF_TARGET_WINDOW_BASE_FIRST = 9'h114;
  localparam logic [8:0] OFF_TARGET_WINDOW_BASE_SECOND = 9'h118;
  localparam logic [8:0] OFF_INTERRUPT_IO_LOCATOR = 9'h11C;
  localparam logic [8:0] OFF_INTERRUPT_MEMORY_LOCATOR = 9'h120;
  localparam logic [8:0] OFF_PCI_ENABLE = 9'h074;
  localparam logic [NUM_WIN-1:0][8:0] OFF_WIN = {OFF_TARGET_WINDOW_BASE_SECOND,
                                                 OFF_TARGET_WINDOW_BASE_FIRST};
  // ==========================================================
  // Field positions and fixed values
  localparam int EVENT_FLAGS_POS = 16;
  localparam int LATENCY_POS = 8;
  localparam int BASE_POS = 21;
  localparam int IO_POS = 2;
  localparam int MEM_POS = 4;
  localparam int ENA_SET_INT_BIT = 3;
  localparam logic [20:0] WIN_LOW_CONST = 21'h00_0008;
  localparam logic [1:0] IO_SPACE = 2'h1;
  localparam logic [3:0] MEM_SPACE = 4'h0;
  localparam logic [15:0] EVENT_FLAGS_FIXED = 16'h0280;
  localparam logic [7:0] CACHE_LINE_WORDS = 8'h04;
  // ==========================================================
  // Values after reset
  localparam logic [15:0] CONTROL_RST = 16'h0000;
  localparam logic [15:0] EVENT_FLAGS_RST = 16'h0000;
  localparam logic [7:0] LATENCY_RST = 8'h00;
  localparam logic [BASE_W-1:0] WIN_BASE_RST = 11'h000;
  localparam logic [29:0] IO_LOCATOR_RST = 30'h0000_0000;
  localparam logic [27:0] MEM_LOCATOR_RST = 28'h000_0000;
  // ==========================================================
  // Sampled PCI side request
  typedef struct packed {
    logic cfg_wr;
    logic cfg_rd;
    logic io_wr;
    logic io_rd;
    logic mem_wr;
    logic mem_rd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } pci_in_t;

  // Byte lanes not enabled keep the old value.
  function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// [blk_link_if.sv]
`timescale 1ns/100ps
interface blk_link_if;
  import addon_pkg::*;
  logic [NUM_WIN-1:0][BASE_W-1:0] win_base;
  logic [NUM_WIN-1:0][MASK_W-1:0] win_mask;
  logic [BASE_W-1:0] addr_hi;
  logic match_en;
  wire logic [NUM_WIN-1:0] win_hit;
  logic int_set;
  logic int_clr;
  logic int_pend;
  modport top_side(output win_base, win_mask, addr_hi, match_en, int_set, int_clr,
                   input win_hit, int_pend);
  modport win_side(input win_base, win_mask, addr_hi, match_en, output win_hit);
  modport int_side(input int_set, int_clr, output int_pend);
endinterface

// [window_match.sv]
`timescale 1ns/100ps
module window_match (
  // Link to the register bank
  blk_link_if.win_side lnk
);
  import addon_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NUM_WIN; g++) begin : g_win
      logic [BASE_W-1:0] care;
      assign care = ~{{(BASE_W-MASK_W){1'b0}}, lnk.win_mask[g]};
      assign lnk.win_hit[g] = lnk.match_en && (lnk.win_base[g] != WIN_BASE_RST) &&
                              (((lnk.win_base[g] ^ lnk.addr_hi) & care) == '0);
    end
  endgenerate
endmodule

// [intr_flag.sv]
`timescale 1ns/100ps
module intr_flag (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Link to the register bank
  blk_link_if.int_side lnk
);
  import addon_pkg::*;

  typedef struct packed {
    logic pending;
  } intr_state_t;

  intr_state_t st_r;
  intr_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (lnk.int_clr) begin
      st_nxt.pending = 1'b0;
    end
    // A set arriving with a clear wins, so no interrupt is lost.
    if (lnk.int_set) begin
      st_nxt.pending = 1'b1;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.int_pend = st_r.pending;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence clear_only;
    lnk.int_clr && !lnk.int_set;
  endsequence

  AST_SET_WINS:
  assert property (lnk.int_set |=> lnk.int_pend) else $error("pending not set");
  AST_CLEAR_NEGATES:
  assert property (clear_only |=> !lnk.int_pend) else $error("pending not cleared");
  AST_PEND_HOLDS:
  assert property (!lnk.int_set && !lnk.int_clr |=> lnk.int_pend == $past(lnk.int_pend))
    else $error("pending changed without cause");
endmodule

// [pci_host_model.sv]
`timescale 1ns/100ps
module pci_host_model (
  // Clock
  input wire logic i_clk_sys,
  // Bus toward the device
  output logic o_pci_clk,
  output logic [5:0] o_op,
  output logic [31:0] o_addr,
  output logic [31:0] o_data,
  output logic [3:0] o_be,
  // Answers from the device
  input wire logic [31:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic [1:0] i_win_hit
);
  initial begin
    o_pci_clk = 1'b0;
    o_op = 6'h00;
    o_addr = 32'h0000_0000;
    o_data = 32'h0000_0000;
    o_be = 4'h0;
  end
  // ==========================================================
  // One transfer per PCI clock
  // The clock stands low between frames, the op lines clear and address, data and enables turn to their inverse, so a
  // device that looks outside the frame sees no stale copy of the last request.
  task automatic xfer(input int kind, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] rd, output logic got,
                      output logic [1:0] hit);
    got = 1'b0;
    rd = 32'hFFFF_FFFF;
    hit = 2'h3;
    @(posedge i_clk_sys);
    o_op <= 6'h01 << kind;
    o_addr <= a;
    o_data <= d;
    o_be <= be;
    repeat (2) @(posedge i_clk_sys);
    o_pci_clk <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk_sys);
      if (i == 3) o_pci_clk <= 1'b0;
      #1;
      if (i_rvalid === 1'b1) begin
        got = 1'b1;
        rd = i_rdata;
      end
      if (i == 4) hit = i_win_hit;
    end
    @(posedge i_clk_sys);
    o_op <= 6'h00;
    o_addr <= ~o_addr;
    o_data <= ~o_data;
    o_be <= ~o_be;
  endtask
endmodule

// [addon_pci_window_bases_and_intr_tb.sv]
`timescale 1ns/100ps
module addon_pci_window_bases_and_intr_tb;
  import addon_pkg::*;
  logic i_clk_sys, i_rst, i_addon_mode, i_config_done, i_cpu_wr, i_cpu_rd;
  logic [NUM_WIN-1:0][MASK_W-1:0] i_win_mask;
  logic [15:0] i_event_set;
  logic [8:0] i_cpu_addr;
  logic [31:0] i_cpu_wdata, o_cpu_rdata, o_pci_rdata, pci_a, pci_d, p_rd, v, a, r;
  logic [3:0] i_cpu_be, pci_be;
  logic [5:0] pci_op;
  logic [1:0] o_win_hit, p_hit;
  logic o_cpu_rvalid, o_pci_rvalid, o_inta_n_o, o_inta_n_oe, pci_clk, p_got, inta_n;
  logic [10:0] fl;
  logic [6:0] msk;
  bit [15:0] m_ctrl, m_flags;
  bit [7:0] m_lat;
  bit [10:0] m_base [2];
  bit [6:0] m_mask [2];
  bit [29:0] m_io;
  bit [27:0] m_mem;
  bit m_pend, m_mode, m_done;
  int err_count, total_checks, cycles, w;

  // The pin is open-drain with a pull-up.
  assign inta_n = o_inta_n_oe ? o_inta_n_o : 1'b1;

  addon_pci_window_bases_and_intr addon_pci_window_bases_and_intr_i (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addon_mode(i_addon_mode),
    .i_config_done(i_config_done), .i_win_mask(i_win_mask), .i_event_set(i_event_set),
    .i_cpu_wr(i_cpu_wr), .i_cpu_rd(i_cpu_rd), .i_cpu_addr(i_cpu_addr),
    .i_cpu_wdata(i_cpu_wdata), .i_cpu_be(i_cpu_be), .o_cpu_rdata(o_cpu_rdata),
    .o_cpu_rvalid(o_cpu_rvalid), .i_pci_clk(pci_clk), .i_pci_cfg_wr(pci_op[0]),
    .i_pci_cfg_rd(pci_op[1]), .i_pci_io_wr(pci_op[2]), .i_pci_io_rd(pci_op[3]),
    .i_pci_mem_wr(pci_op[4]), .i_pci_mem_rd(pci_op[5]), .i_pci_addr(pci_a),
    .i_pci_data(pci_d), .i_pci_be(pci_be), .o_pci_rdata(o_pci_rdata),
    .o_pci_rvalid(o_pci_rvalid), .o_win_hit(o_win_hit), .o_inta_n_o(o_inta_n_o),
    .o_inta_n_oe(o_inta_n_oe));

  pci_host_model pci_host_model_i (
    .i_clk_sys(i_clk_sys), .o_pci_clk(pci_clk), .o_op(pci_op), .o_addr(pci_a),
    .o_data(pci_d), .o_be(pci_be), .i_rdata(o_pci_rdata), .i_rvalid(o_pci_rvalid),
    .i_win_hit(o_win_hit));

  initial begin
    i_clk_sys = 1'b0;
    forever #20 i_clk_sys = ~i_clk_sys;
  end

  // ==========================================================
  // Checking
  task automatic chk_data(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_flag(input string n, input logic [1:0] e, input logic [1:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // The run needs about 900 cycles; the ceiling leaves wide margin.
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      stop_test;
    end
  end

  // ==========================================================
  // Model
  function automatic logic [31:0] exp_cfg(input logic [8:0] off);
    case (off)
      OFF_PCI_CONTROL_WORD: return {m_flags | 16'h0280, m_ctrl};
      OFF_CACHE_LINE: return {16'h0000, m_lat, 8'h04};
      OFF_INTERRUPT_IO_LOCATOR: return {m_io, 2'h1};
      OFF_INTERRUPT_MEMORY_LOCATOR: return {m_mem, 4'h0};
      default: return {m_base[off == OFF_TARGET_WINDOW_BASE_SECOND], 21'h00_0008};
    endcase
  endfunction

  function automatic logic [1:0] exp_hit(input logic [31:0] ad);
    logic [1:0] h;
    for (int k = 0; k < 2; k++) begin
      h[k] = m_mode && m_done && m_base[k] != 0 &&
             ((ad[31:21] ^ m_base[k]) & ~{4'h0, m_mask[k]}) == 0;
    end
    return h;
  endfunction

  // ==========================================================
  // Bus tasks
  task automatic cpu_wr(input logic [8:0] ad, input logic [31:0] d, input logic [3:0] be);
    @(posedge i_clk_sys);
    i_cpu_wr <= 1'b1;
    i_cpu_addr <= ad;
    i_cpu_wdata <= d;
    i_cpu_be <= be;
    @(posedge i_clk_sys);
    i_cpu_wr <= 1'b0;
  endtask

  task automatic cpu_rd(input logic [8:0] ad, output logic [31:0] rd);
    rd = 32'hFFFF_FFFF;
    @(posedge i_clk_sys);
    i_cpu_rd <= 1'b1;
    i_cpu_addr <= ad;
    @(posedge i_clk_sys);
    i_cpu_rd <= 1'b0;
    repeat (3) begin
      #1;
      if (o_cpu_rvalid === 1'b1) rd = o_cpu_rdata;
      @(posedge i_clk_sys);
    end
  endtask

  task automatic pci(input int k, input logic [31:0] ad, input logic [31:0] d,
                     input logic [3:0] be);
    pci_host_model_i.xfer(k, ad, d, be, p_rd, p_got, p_hit);
  endtask

  task automatic cfg_chk(input logic [8:0] off);
    logic [31:0] m;
    m = (off == OFF_CACHE_LINE) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    pci(1, {23'h0, off}, $urandom(), 4'hF);
    chk_data("cfg_read", exp_cfg(off) & m, p_rd & m);
  endtask

  task automatic int_chk(input logic [31:0] ad, input int k);
    #1;
    chk_flag("inta_n", {1'b0, !m_pend}, {1'b0, inta_n});
    cpu_rd(OFF_PCI_ENABLE, r);
    chk_data("enable_read", {28'h0, m_pend, 3'h0}, r);
    pci(3 + 2 * k, ad, $urandom(), 4'hF);
    chk_flag("int_answer", 2'h1, {1'b0, p_got});
    chk_data("int_reg", {31'h0, m_pend}, p_rd);
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    i_rst = 1'b1;
    {i_addon_mode, i_config_done, i_cpu_wr, i_cpu_rd} = 4'h0;
    i_win_mask = '0;
    i_event_set = 16'h0000;
    i_cpu_addr = 9'h000;
    i_cpu_wdata = 32'h0000_0000;
    i_cpu_be = 4'h0;
    void'($urandom(32'hABEB));
    repeat (10) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    for (int k = 0; k < NUM_WIN; k++) cfg_chk(OFF_WIN[k]);
    cfg_chk(OFF_INTERRUPT_IO_LOCATOR);
    cfg_chk(OFF_INTERRUPT_MEMORY_LOCATOR);
    for (int m = 0; m < 2; m++) begin
      m_mode = m[0];
      i_addon_mode <= m_mode;
      v = $urandom();
      cpu_wr(OFF_PCI_CONTROL_WORD, v, 4'h3);
      if (m_mode) m_ctrl = v[15:0];
      v = $urandom();
      cpu_wr(OFF_CACHE_LINE, v, 4'h2);
      if (m_mode) m_lat = v[15:8];
      v = $urandom();
      pci(0, {23'h0, OFF_PCI_CONTROL_WORD}, v, 4'h3);
      if (!m_mode) m_ctrl = v[15:0];
      v = $urandom();
      pci(0, {23'h0, OFF_CACHE_LINE}, v, 4'h2);
      if (!m_mode) m_lat = v[15:8];
      cfg_chk(OFF_PCI_CONTROL_WORD);
      cfg_chk(OFF_CACHE_LINE);
      cpu_rd(OFF_PCI_CONTROL_WORD, r);
      chk_data("cpu_ctrl_read", exp_cfg(OFF_PCI_CONTROL_WORD), r);
    end
    for (int k = 0; k < 3; k++) begin
      v = $urandom();
      @(posedge i_clk_sys);
      i_event_set <= v[15:0];
      @(posedge i_clk_sys);
      i_event_set <= 16'h0000;
      m_flags = m_flags | v[15:0];
      cfg_chk(OFF_PCI_CONTROL_WORD);
      v = $urandom();
      pci(0, {23'h0, OFF_PCI_CONTROL_WORD}, v, 4'hC);
      m_flags = m_flags & ~v[31:16];
      cfg_chk(OFF_PCI_CONTROL_WORD);
    end
    cpu_wr(OFF_PCI_CONTROL_WORD, 32'hFFFF_0000, 4'hC);
    m_flags = 16'h0000;
    cfg_chk(OFF_PCI_CONTROL_WORD);
    v = $urandom();
    pci(0, {23'h0, OFF_INTERRUPT_IO_LOCATOR}, v, 4'hF);
    m_io = v[31:2];
    v = $urandom();
    pci(0, {23'h0, OFF_INTERRUPT_MEMORY_LOCATOR}, v, 4'hF);
    m_mem = v[31:4];
    cfg_chk(OFF_INTERRUPT_IO_LOCATOR);
    cfg_chk(OFF_INTERRUPT_MEMORY_LOCATOR);
    for (int t = 0; t < 12; t++) begin
      w = t % 2;
      v = $urandom();
      if (t < 2) v[31:21] = 11'h000;
      msk = (t < 4) ? 7'h00 : (t < 6) ? 7'h7F : 7'($urandom());
      fl = (t % 3 == 0) ? 11'h000 : 11'h001 << ($urandom() % 11);
      m_mode = (t != 8);
      m_done = (t != 9);
      m_mask[w] = msk;
      i_addon_mode <= m_mode;
      i_config_done <= m_done;
      i_win_mask[w] <= msk;
      pci(0, {23'h0, OFF_WIN[w]}, v, 4'hF);
      m_base[w] = v[31:21];
      cfg_chk(OFF_WIN[w]);
      a = {m_base[w] ^ fl, 21'($urandom())};
      pci(4 + w, a, $urandom(), 4'hF);
      chk_flag("win_hit", exp_hit(a), p_hit);
    end
    for (int k = 0; k < 2; k++) begin
      a = k ? {m_mem, 4'h0} : {m_io, 2'h0};
      cpu_wr(OFF_PCI_ENABLE, 32'h0000_0008, 4'h1);
      m_pend = 1'b1;
      repeat (2) @(posedge i_clk_sys);
      int_chk(a, k);
      pci(2 + 2 * k, a, $urandom(), 4'h1);
      m_pend = 1'b0;
      repeat (2) @(posedge i_clk_sys);
      int_chk(a, k);
    end
    cpu_rd(9'h1F0, r);
    chk_data("cpu_unmapped", 32'h0000_0000, r);
    stop_test;
  end
endmodule
